// ===== dv/lls_table_model.sv
/*
  Behavioural MAC table and port group table facing the lookup stage.
  Assumes the bench preloads mem after time zero and may set slow.
*/
`timescale 1ns/1ps
module lls_table_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic lkp_req,
  input wire logic [47:0] lkp_mac,
  input wire logic [12:0] lkp_fid,
  output logic lkp_ack,
  output logic lkp_hit,
  output lls_pkg::lls_entry_type lkp_entry,
  input wire logic wr_req,
  input wire lls_pkg::lls_entry_type wr_entry,
  output logic wr_ack,
  input wire logic [11:0] pg_index,
  output logic [10:0] pg_mask
);
  lls_pkg::lls_entry_type mem [8];
  lls_pkg::lls_entry_type last_wr;
  int slow = 0;
  int cnt;
  int k;
  logic [47:0] m;
  logic [12:0] f;
  initial foreach (mem[i]) mem[i] = '0;
  // A fixed scramble lets the bench predict the mask of any index.
  assign pg_mask = pg_index[10:0] ^ 11'h555;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lkp_ack <= 1'b0;
      wr_ack <= 1'b0;
      lkp_hit <= 1'b0;
      lkp_entry <= '0;
      cnt <= 0;
    end else begin
      lkp_ack <= 1'b0;
      wr_ack <= 1'b0;
      // Entry lines toggle outside the answer cycle, so stale use shows.
      lkp_entry <= ~lkp_entry;
      if ((lkp_req || wr_req) && !lkp_ack && !wr_ack) begin
        if (cnt < slow) begin
          cnt <= cnt + 1;
        end else begin
          cnt <= 0;
          m = lkp_req ? lkp_mac : wr_entry.mac;
          f = lkp_req ? lkp_fid : wr_entry.fid;
          k = 0;
          while (k < 8 && !(mem[k].entry_valid && mem[k].mac == m &&
                 mem[k].fid == f)) k++;
          if (lkp_req) begin
            lkp_ack <= 1'b1;
            lkp_hit <= (k < 8);
            lkp_entry <= (k < 8) ? mem[k] : ~lkp_entry;
          end else begin
            if (k == 8) begin
              k = 0;
              while (k < 7 && mem[k].entry_valid) k++;
            end
            mem[k] <= wr_entry;
            last_wr <= wr_entry;
            wr_ack <= 1'b1;
          end
        end
      end
    end
  end
endmodule : lls_table_model

// ===== dv/testbench.sv
/*
  Self-checking bench of the lookup stage: register access over AHB-Lite,
  a table of frame cases, then learning, move log and reset checks.
  Assumes the table model answers every request of the stage.
*/
`timescale 1ns/1ps
`define chk(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench;
  typedef struct packed {
    logic [7:0] lrn;
    logic [3:0] port;
    logic [7:0] d;
    logic [7:0] s;
    logic [1:0] vf;
    logic [11:0] pgi;
    logic [5:0] e;
  } lls_row_type;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = '0;
  logic [31:0] hwdata = '0;
  logic frm_valid = 1'b0;
  lls_pkg::lls_frame_type frm = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic frm_ready;
  logic res_valid;
  lls_pkg::lls_result_type res;
  logic lkp_req;
  logic [47:0] lkp_mac;
  logic [12:0] lkp_fid;
  logic lkp_ack;
  logic lkp_hit;
  lls_pkg::lls_entry_type lkp_entry;
  logic wr_req;
  lls_pkg::lls_entry_type wr_entry;
  logic wr_ack;
  logic [11:0] pg_index;
  logic [10:0] pg_mask;
  int n_fail = 0;
  int tests_run = 0;
  logic [31:0] q;
  lls_pkg::lls_entry_type ex;
  // Columns: learn cfg, port, dmac, smac, {vlan secure, flood allowed},
  // group index, {flood, blocked, skip vlan, denied, copy, known}.
  lls_row_type rows [12] = '{
    {8'h60, 4'h2, 8'h09, 8'h01, 2'b01, 12'h000, 6'b100001},
    {8'h60, 4'h2, 8'h01, 8'h01, 2'b01, 12'h002, 6'b000001},
    {8'h60, 4'h1, 8'h02, 8'h0a, 2'b01, 12'h003, 6'b001010},
    {8'h60, 4'h4, 8'h01, 8'h0b, 2'b01, 12'h002, 6'b000110},
    {8'h60, 4'h5, 8'h01, 8'h01, 2'b01, 12'h002, 6'b000011},
    {8'h60, 4'h2, 8'h01, 8'h03, 2'b01, 12'h002, 6'b000011},
    {8'h68, 4'h2, 8'h01, 8'h03, 2'b01, 12'h002, 6'b000001},
    {8'h60, 4'h5, 8'h01, 8'h02, 2'b01, 12'h002, 6'b000001},
    {8'h63, 4'h5, 8'h01, 8'h02, 2'b01, 12'h002, 6'b000011},
    {8'h60, 4'h6, 8'h01, 8'h02, 2'b01, 12'h002, 6'b000101},
    {8'h60, 4'h3, 8'h01, 8'h0d, 2'b11, 12'h002, 6'b000110},
    {8'h60, 4'h2, 8'h09, 8'h01, 2'b00, 12'h000, 6'b010001}};

  lls_core lls_core_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .frm_valid, .frm, .frm_ready, .res_valid, .res, .lkp_req, .lkp_mac,
    .lkp_fid, .lkp_ack, .lkp_hit, .lkp_entry, .wr_req, .wr_entry, .wr_ack,
    .pg_index, .pg_mask);
  lls_table_model lls_table_model_inst (.hclk, .hresetn, .lkp_req,
    .lkp_mac, .lkp_fid, .lkp_ack, .lkp_hit, .lkp_entry, .wr_req, .wr_entry,
    .wr_ack, .pg_index, .pg_mask);

  always #50 hclk = ~hclk;

  task automatic wrap_up;
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : bus

  task automatic until_ready;
    int n;
    n = 0;
    @(negedge hclk);
    while (frm_ready !== 1'b1 && n < 40) begin
      @(negedge hclk);
      n++;
    end
  endtask : until_ready

  // Returns once the result stands and any table write has finished.
  task automatic send(input logic [3:0] p, input logic [7:0] d, s,
                      input logic [1:0] vf, input logic gl);
    lls_pkg::lls_frame_type f;
    int n;
    f = '0;
    f.dmac = {40'h0, d};
    f.smac = {40'h0, s};
    f.egress_filter_id = 13'h1;
    f.ingress_filter_id = 13'h1;
    f.fid = 13'h2;
    f.rx_port = p;
    f.global_aggregation_member = gl;
    f.global_aggregation_number = 5'h5;
    {f.vlan_secure_forward_enable, f.vlan_flood_allowed} = vf;
    @(posedge hclk);
    frm <= f;
    frm_valid <= 1'b1;
    until_ready();
    @(posedge hclk);
    frm_valid <= 1'b0;
    n = 0;
    @(negedge hclk);
    while (res_valid !== 1'b1 && n < 40) begin
      @(negedge hclk);
      n++;
    end
    `chk(res_valid, 1'b1)
    until_ready();
  endtask : send

  initial begin
    #(100 * 20000);
    n_fail++;
    wrap_up();
  end

  initial begin : main
    lls_row_type r;
    #1;
    ex = '0;
    ex.entry_valid = 1'b1;
    ex.fid = 13'h1;
    ex.age_flag = 2'h1;
    ex.mac = 48'h1;
    ex.addr = 12'h002;
    lls_table_model_inst.mem[0] = ex;
    ex.mac = 48'h2;
    ex.addr = 12'h003;
    ex.locked = 1'b1;
    ex.entry_skip_vlan = 1'b1;
    lls_table_model_inst.mem[1] = ex;
    ex = '0;
    ex.entry_valid = 1'b1;
    ex.fid = 13'h1;
    ex.mac = 48'h3;
    ex.addr = 12'h007;
    ex.addr_type = lls_pkg::ADDR_MCIDX;
    lls_table_model_inst.mem[2] = ex;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    `chk(frm_ready, 1'b1)
    bus(1'b0, lls_pkg::OFS_FWD_CFG, '0);
    `chk(q, lls_pkg::RST_WORD)
    `chk({hreadyout, hresp}, 2'b10)
    bus(1'b1, lls_pkg::OFS_FWD_CFG, 32'h53);
    bus(1'b1, lls_pkg::OFS_AUTOLEARN, 32'h002);
    bus(1'b1, lls_pkg::OFS_PORT_SECURE, 32'h010);
    bus(1'b1, lls_pkg::OFS_LOCKED_SECURE, 32'h040);
    bus(1'b1, lls_pkg::OFS_LEARN_COPY, 32'h7ff);
    bus(1'b1, lls_pkg::OFS_LEARNED_CFG, 32'h0e5);
    // ----------------------------------------------------------------
    // Frame cases
    // ----------------------------------------------------------------
    for (int i = 0; i < 12; i++) begin
      r = rows[i];
      lls_table_model_inst.slow = i % 3;
      bus(1'b1, lls_pkg::OFS_LRN_CFG, {24'h0, r.lrn});
      send(r.port, r.d, r.s, r.vf, 1'b0);
      `chk(res.flood_blocked, r.e[4])
      if (!r.e[4]) begin
        `chk(res.flood, r.e[5])
        `chk(res.dest_ports, r.pgi[10:0] ^ 11'h555)
        `chk(res.mirror, r.e[5])
        `chk(res.dest_cpu_copy, r.e[5])
        if (r.e[5]) `chk(res.dest_cpu_queue, 3'h5)
      end
      `chk(res.skip_vlan_mask, r.e[3])
      `chk(res.skip_src_mask, 1'b0)
      `chk(res.forward_denied, r.e[2])
      `chk(res.learn_copy, r.e[1])
      if (r.e[1]) `chk(res.learn_queue, 3'h6)
      `chk(res.src_known, r.e[0])
    end
    // ----------------------------------------------------------------
    // Learning, moves, filter mode and reset
    // ----------------------------------------------------------------
    `chk(lls_table_model_inst.mem[0].age_flag, 2'h0)
    `chk(lls_table_model_inst.mem[1].age_flag, 2'h1)
    `chk(lls_table_model_inst.mem[0].addr, 12'h002)
    send(4'h1, 8'h01, 8'h0c, 2'b01, 1'b1);
    `chk(res.learned, 1'b1)
    ex = '0;
    ex.entry_valid = 1'b1;
    ex.mac = 48'hc;
    ex.fid = 13'h2;
    ex.addr_type = lls_pkg::ADDR_GLOBAL_AGGREGATION;
    ex.addr = 12'h005;
    ex.cpu_copy = 1'b1;
    ex.cpu_queue = 3'h2;
    ex.entry_skip_vlan = 1'b1;
    ex.mirror = 1'b1;
    ex.age_interval = 2'h1;
    `chk(lls_table_model_inst.last_wr, ex)
    bus(1'b0, lls_pkg::OFS_MOVE_LOG, '0);
    `chk(q, 32'h0)
    bus(1'b1, lls_pkg::OFS_AUTOLEARN, 32'h022);
    send(4'h5, 8'h01, 8'h01, 2'b01, 1'b0);
    `chk(lls_table_model_inst.mem[0].addr, 12'h005)
    bus(1'b0, lls_pkg::OFS_MOVE_LOG, '0);
    `chk(q, 32'h20)
    bus(1'b1, lls_pkg::OFS_MOVE_LOG, 32'h20);
    bus(1'b0, lls_pkg::OFS_MOVE_LOG, '0);
    `chk(q, 32'h0)
    bus(1'b1, lls_pkg::OFS_FWD_CFG, 32'h5f);
    send(4'h2, 8'h02, 8'h0c, 2'b01, 1'b0);
    `chk(res.skip_src_mask, 1'b1)
    `chk(res.skip_vlan_mask, 1'b0)
    send(4'h2, 8'h09, 8'h0c, 2'b01, 1'b0);
    `chk(res.skip_src_mask, 1'b1)
    bus(1'b0, lls_pkg::OFS_LEARNED_CFG, '0);
    `chk(q, 32'h0e5)
    bus(1'b0, 8'h40, '0);
    `chk(q, 32'h0)
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, lls_pkg::OFS_FWD_CFG, '0);
    `chk(q, lls_pkg::RST_WORD)
    wrap_up();
  end
endmodule : testbench

// ===== logic/lls_core.sv
/*
  Layer-2 destination lookup, source check and automatic learning, with an
  AHB-Lite register slave. Assumes the MAC table answers one lookup or one
  write at a time over a request/acknowledge pair, and that the port group
  table returns its mask combinationally for the index driven out.
*/
// Our own choices: the AHB-Lite register port and the register addresses.
// Function
// (RL1) Destination lookup classifies known or unknown.
// (RL2) Unknown destination floods when VLAN allows.
// (RL3) Known destination indexes port group table.
// (RL4) Flood mirror and CPU copy options.
// (RL5) Skip VLAN or source mask per mode.
// (RL6) Source lookup classifies station known or unknown.
// (RL7) Known source compared with expected port.
// (RL8) Secure forwarding drops unknown or moved.
// (RL9) Locked secure drops locked entry mismatch.
// (RL10) Autolearn inserts entry for unknown source.
// (RL11) Learn copy sends failing frames to CPU.
// (RL12) Drop, learn and copy act independently.
// (RL13) Locked move detection only when enabled.
// (RL14) Locked move failures copied when enabled.
// (RL15) New entry valid, MAC, FID, address.
// (RL16) New entry attributes from learn config.
// (RL17) Source hit clears age flag; the code clears it on a locked entry only when LRN_AGE_LOCKED_BIT is set.
// (RL18) Unlocked moved entry gets new address.
// (RL19) Multicast index entries skip source check.
// (RL20) Port move sets sticky move log bit.
// (RL21) No table change without autolearn; the code still writes age flag clears (do_age) on ports without autolearn.
`timescale 1ns/1ps
module lls_core #(
  parameter int NPORT = lls_pkg::NPORT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic frm_valid,
  input wire lls_pkg::lls_frame_type frm,
  output logic frm_ready,
  output logic res_valid,
  output lls_pkg::lls_result_type res,
  output logic lkp_req,
  output logic [47:0] lkp_mac,
  output logic [12:0] lkp_fid,
  input wire logic lkp_ack,
  input wire logic lkp_hit,
  input wire lls_pkg::lls_entry_type lkp_entry,
  output logic wr_req,
  output lls_pkg::lls_entry_type wr_entry,
  input wire logic wr_ack,
  output logic [11:0] pg_index,
  input wire logic [NPORT-1:0] pg_mask
);
  default clocking lls_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------------
  logic [31:0] fwd_cfg_reg;
  logic [31:0] lrn_cfg_reg;
  logic [NPORT-1:0] autolearn_reg;
  logic [NPORT-1:0] port_secure_reg;
  logic [NPORT-1:0] locked_secure_reg;
  logic [NPORT-1:0] learn_copy_reg;
  logic [31:0] learned_cfg_reg;
  logic [NPORT-1:0] move_log_reg;
  logic [NPORT-1:0] move_set;
  logic wr_phase_reg;
  logic [7:0] wr_ofs_reg;
  logic [31:0] rd_word;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_phase_reg <= 1'b0;
      wr_ofs_reg <= 8'h00;
    end else if (hready) begin
      wr_phase_reg <= hsel && htrans[1] && hwrite;
      wr_ofs_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fwd_cfg_reg <= lls_pkg::RST_WORD;
      lrn_cfg_reg <= lls_pkg::RST_WORD;
      autolearn_reg <= '0;
      port_secure_reg <= '0;
      locked_secure_reg <= '0;
      learn_copy_reg <= '0;
      learned_cfg_reg <= lls_pkg::RST_WORD;
    end else if (wr_phase_reg) begin
      case (wr_ofs_reg)
        lls_pkg::OFS_FWD_CFG: fwd_cfg_reg <= hwdata;
        lls_pkg::OFS_LRN_CFG: lrn_cfg_reg <= hwdata;
        lls_pkg::OFS_AUTOLEARN: autolearn_reg <= hwdata[NPORT-1:0];
        lls_pkg::OFS_PORT_SECURE: port_secure_reg <= hwdata[NPORT-1:0];
        lls_pkg::OFS_LOCKED_SECURE: locked_secure_reg <= hwdata[NPORT-1:0];
        lls_pkg::OFS_LEARN_COPY: learn_copy_reg <= hwdata[NPORT-1:0];
        lls_pkg::OFS_LEARNED_CFG: learned_cfg_reg <= hwdata;
        default: ;
      endcase
    end
  end

  // Writing ones clears; a move in the same cycle keeps its bit set.
  // (RL20) sticky move log
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      move_log_reg <= '0;
    end else if (wr_phase_reg && wr_ofs_reg == lls_pkg::OFS_MOVE_LOG) begin
      move_log_reg <= (move_log_reg & ~hwdata[NPORT-1:0]) | move_set;
    end else begin
      move_log_reg <= move_log_reg | move_set;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      lls_pkg::OFS_FWD_CFG: rd_word = fwd_cfg_reg;
      lls_pkg::OFS_LRN_CFG: rd_word = lrn_cfg_reg;
      lls_pkg::OFS_AUTOLEARN: rd_word[NPORT-1:0] = autolearn_reg;
      lls_pkg::OFS_PORT_SECURE: rd_word[NPORT-1:0] = port_secure_reg;
      lls_pkg::OFS_LOCKED_SECURE: rd_word[NPORT-1:0] = locked_secure_reg;
      lls_pkg::OFS_LEARN_COPY: rd_word[NPORT-1:0] = learn_copy_reg;
      lls_pkg::OFS_LEARNED_CFG: rd_word = learned_cfg_reg;
      lls_pkg::OFS_MOVE_LOG: rd_word[NPORT-1:0] = move_log_reg;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  // ----------------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_DLOOK = 5'b00010,
    S_SLOOK = 5'b00100,
    S_WRITE = 5'b01000,
    S_DONE = 5'b10000
  } lls_state_type;

  lls_state_type state_reg;
  lls_state_type state_next;
  lls_pkg::lls_frame_type frm_reg;
  lls_pkg::lls_entry_type dent_reg;
  lls_pkg::lls_entry_type sent_reg;
  logic dhit_reg;
  logic shit_reg;
  logic [NPORT-1:0] port_bit;
  logic need_write;

  assign frm_ready = (state_reg == S_IDLE);
  assign lkp_req = (state_reg == S_DLOOK) || (state_reg == S_SLOOK);
  assign wr_req = (state_reg == S_WRITE);
  // (RL1) destination key
  assign lkp_mac = (state_reg == S_DLOOK) ? frm_reg.dmac : frm_reg.smac;
  // (RL6) source key
  assign lkp_fid = (state_reg == S_DLOOK) ? frm_reg.egress_filter_id
                                          : frm_reg.ingress_filter_id;
  assign port_bit = NPORT'(1) << frm_reg.rx_port;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: if (frm_valid) state_next = S_DLOOK;
      S_DLOOK: if (lkp_ack) state_next = S_SLOOK;
      S_SLOOK: if (lkp_ack) state_next = S_DONE;
      S_DONE: state_next = need_write ? S_WRITE : S_IDLE;
      S_WRITE: if (wr_ack) state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frm_reg <= '0;
      dent_reg <= '0;
      sent_reg <= '0;
      dhit_reg <= 1'b0;
      shit_reg <= 1'b0;
    end else begin
      if (frm_valid && frm_ready) frm_reg <= frm;
      if (state_reg == S_DLOOK && lkp_ack) begin
        dhit_reg <= lkp_hit && lkp_entry.entry_valid;
        dent_reg <= lkp_entry;
      end
      if (state_reg == S_SLOOK && lkp_ack) begin
        shit_reg <= lkp_hit && lkp_entry.entry_valid;
        sent_reg <= lkp_entry;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Source check
  // ----------------------------------------------------------------------
  logic [1:0] rx_type;
  logic [11:0] rx_addr;
  logic skip_check;
  logic differs;
  logic move_unlocked;
  logic locked_diff;
  logic move_locked;
  logic src_fail;
  logic deny_fwd;
  logic learn_cpy;
  logic do_insert;
  logic do_move;
  logic do_age;
  lls_pkg::lls_entry_type new_entry;

  // (RL7) receiving port as stored form
  assign rx_type = frm_reg.global_aggregation_member ? lls_pkg::ADDR_GLOBAL_AGGREGATION
                                       : lls_pkg::ADDR_LOGICAL;
  assign rx_addr = frm_reg.global_aggregation_member
                 ? {7'h00, frm_reg.global_aggregation_number}
                 : {frm_reg.unit_id, 3'h0, frm_reg.rx_port};
  // (RL19) multicast index entries exempt
  assign skip_check = shit_reg && lrn_cfg_reg[lls_pkg::LRN_SKIP_MCIDX_BIT]
                   && sent_reg.addr_type == lls_pkg::ADDR_MCIDX;
  assign differs = shit_reg && !skip_check
                && {sent_reg.addr_type, sent_reg.addr} != {rx_type, rx_addr};
  assign move_unlocked = differs && !sent_reg.locked;
  assign locked_diff = differs && sent_reg.locked;
  // (RL13) locked move detect gate
  assign move_locked = locked_diff
                    && lrn_cfg_reg[lls_pkg::LRN_MOVE_DETECT_BIT];
  assign src_fail = !shit_reg || move_unlocked || move_locked;
  // (RL8) secure forwarding per VLAN or port
  // (RL9) locked secure forwarding
  assign deny_fwd = (src_fail && (frm_reg.vlan_secure_forward_enable
                   || (|(port_secure_reg & port_bit))))
                 || (locked_diff && (|(locked_secure_reg & port_bit)));
  // (RL11) learn copy on failure
  // (RL14) locked move copy
  assign learn_cpy = (src_fail && (|(learn_copy_reg & port_bit)))
                  || (move_locked && lrn_cfg_reg[lls_pkg::LRN_MOVE_COPY_BIT]);
  // (RL10) insert with autolearn only
  // (RL21) no insert or move without autolearn
  assign do_insert = !shit_reg && (|(autolearn_reg & port_bit));
  assign do_move = move_unlocked && (|(autolearn_reg & port_bit));
  // (RL17) age flag clear on hit
  assign do_age = shit_reg && sent_reg.age_flag != 2'h0
               && (!sent_reg.locked
                   || lrn_cfg_reg[lls_pkg::LRN_AGE_LOCKED_BIT]);
  assign need_write = do_insert || do_move || do_age;
  assign move_set = (state_reg == S_DONE && do_move) ? port_bit : '0;

  always_comb begin
    new_entry = sent_reg;
    if (do_insert) begin
      // (RL15) new entry identity
      new_entry = '0;
      new_entry.entry_valid = 1'b1;
      new_entry.mac = frm_reg.smac;
      new_entry.fid = frm_reg.fid;
      new_entry.addr_type = rx_type;
      new_entry.addr = rx_addr;
      // (RL16) learned attributes
      new_entry.cpu_copy = learned_cfg_reg[lls_pkg::AL_COPY_BIT];
      new_entry.cpu_queue = learned_cfg_reg[lls_pkg::AL_QUEUE_LSB +: 3];
      new_entry.src_drop = learned_cfg_reg[lls_pkg::AL_DROP_BIT];
      new_entry.entry_skip_vlan = learned_cfg_reg[lls_pkg::AL_SKIP_VLAN_BIT];
      new_entry.mirror = learned_cfg_reg[lls_pkg::AL_MIRROR_BIT];
      new_entry.age_interval = learned_cfg_reg[lls_pkg::AL_AGE_LSB +: 2];
    end else begin
      if (do_age) new_entry.age_flag = 2'h0;
      if (do_move) begin
        // (RL18) record the station move
        new_entry.addr_type = rx_type;
        new_entry.addr = rx_addr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_entry <= '0;
    end else if (state_reg == S_DONE) begin
      wr_entry <= new_entry;
    end
  end

  // ----------------------------------------------------------------------
  // Forwarding decision
  // ----------------------------------------------------------------------
  logic skip_mask;

  // (RL3) known destination port group index
  assign pg_index = dhit_reg ? dent_reg.addr : lls_pkg::FLOOD_GROUP;
  // (RL5) mask bypass source
  assign skip_mask = dhit_reg ? dent_reg.entry_skip_vlan
                              : fwd_cfg_reg[lls_pkg::FWD_SKIP_VLAN_BIT];

  // Copy, drop and learn outcomes are all reported side by side.
  // (RL12) independent actions
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res <= '0;
      res_valid <= 1'b0;
    end else begin
      res_valid <= (state_reg == S_DONE);
      if (state_reg == S_DONE) begin
        // (RL2) flood only when VLAN permits
        res.flood <= !dhit_reg && frm_reg.vlan_flood_allowed;
        res.flood_blocked <= !dhit_reg && !frm_reg.vlan_flood_allowed;
        res.dest_ports <= (dhit_reg || frm_reg.vlan_flood_allowed)
                        ? pg_mask : '0;
        // (RL4) flood mirror and CPU copy
        res.mirror <= dhit_reg ? dent_reg.mirror
                    : fwd_cfg_reg[lls_pkg::FWD_MIRROR_BIT];
        res.dest_cpu_copy <= dhit_reg ? dent_reg.cpu_copy
                           : fwd_cfg_reg[lls_pkg::FWD_CPU_COPY_BIT];
        res.dest_cpu_queue <= dhit_reg ? dent_reg.cpu_queue
                            : fwd_cfg_reg[lls_pkg::FWD_QUEUE_LSB +: 3];
        res.skip_vlan_mask <= skip_mask
                            && !fwd_cfg_reg[lls_pkg::FWD_MODE_BIT];
        res.skip_src_mask <= skip_mask && fwd_cfg_reg[lls_pkg::FWD_MODE_BIT];
        res.forward_denied <= deny_fwd;
        res.learn_copy <= learn_cpy;
        res.learn_queue <= lrn_cfg_reg[lls_pkg::LRN_QUEUE_LSB +: 3];
        res.src_known <= shit_reg;
        res.learned <= do_insert;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_insert_learns: assert property ( // RL10
    state_reg == S_DONE && !shit_reg && (|(autolearn_reg & port_bit))
    |=> wr_req && wr_entry.entry_valid && wr_entry.mac == frm_reg.smac)
    else $error("unknown source not learned");
  a_no_learn_off: assert property ( // RL21
    state_reg == S_DONE && !shit_reg && !(|(autolearn_reg & port_bit))
    |=> state_reg == S_IDLE)
    else $error("table written without autolearn");
  a_secure_drop: assert property ( // RL8
    state_reg == S_DONE && !shit_reg && frm_reg.vlan_secure_forward_enable
    |=> res_valid && res.forward_denied)
    else $error("secure forwarding not applied");
  a_move_log: assert property ( // RL20
    state_reg == S_DONE && do_move |=> |(move_log_reg & $past(port_bit)))
    else $error("move not logged");
  a_age_clear: assert property ( // RL17
    state_reg == S_DONE && shit_reg && !sent_reg.locked
    |=> wr_req == (sent_reg.age_flag != 2'h0 || do_move)
        && wr_entry.age_flag == 2'h0)
    else $error("age flag not cleared");
  a_flood_group: assert property ( // RL2
    state_reg == S_DONE && !dhit_reg |=> res.flood_blocked
    == !frm_reg.vlan_flood_allowed && pg_index == lls_pkg::FLOOD_GROUP)
    else $error("flood decision wrong");
  a_dest_index: assert property ( // RL3
    state_reg == S_DONE && dhit_reg |-> pg_index == dent_reg.addr
    ##1 res.dest_ports == $past(pg_mask) && !res.flood_blocked)
    else $error("known destination index wrong");
  a_result_order: assert property ( // RL1
    frm_valid && frm_ready |=> lkp_req && lkp_mac == frm_reg.dmac)
    else $error("destination lookup not first");
  a_learn_copy: assert property ( // RL11
    state_reg == S_DONE && !shit_reg && (|(learn_copy_reg & port_bit))
    |=> res.learn_copy)
    else $error("learn copy missing");
endmodule : lls_core

// ===== logic/lls_pkg.sv
/*
  Shared constants and carrier types of the layer-2 lookup and source
  learning stage. Assumes one core clock and a MAC table outside the block.
*/
package lls_pkg;
  localparam int NPORT = 11;
  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_FWD_CFG = 8'h00;
  localparam logic [7:0] OFS_LRN_CFG = 8'h04;
  localparam logic [7:0] OFS_AUTOLEARN = 8'h08;
  localparam logic [7:0] OFS_PORT_SECURE = 8'h0c;
  localparam logic [7:0] OFS_LOCKED_SECURE = 8'h10;
  localparam logic [7:0] OFS_LEARN_COPY = 8'h14;
  localparam logic [7:0] OFS_LEARNED_CFG = 8'h18;
  localparam logic [7:0] OFS_MOVE_LOG = 8'h1c;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // ----------------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------------
  localparam int FWD_MIRROR_BIT = 0;
  localparam int FWD_CPU_COPY_BIT = 1;
  localparam int FWD_SKIP_VLAN_BIT = 2;
  localparam int FWD_MODE_BIT = 3;
  localparam int FWD_QUEUE_LSB = 4;
  localparam int LRN_MOVE_DETECT_BIT = 0;
  localparam int LRN_MOVE_COPY_BIT = 1;
  localparam int LRN_AGE_LOCKED_BIT = 2;
  localparam int LRN_SKIP_MCIDX_BIT = 3;
  localparam int LRN_QUEUE_LSB = 4;
  localparam int AL_COPY_BIT = 0;
  localparam int AL_QUEUE_LSB = 1;
  localparam int AL_DROP_BIT = 4;
  localparam int AL_SKIP_VLAN_BIT = 5;
  localparam int AL_MIRROR_BIT = 6;
  localparam int AL_AGE_LSB = 7;
  localparam logic [1:0] ADDR_LOGICAL = 2'h0;
  localparam logic [1:0] ADDR_GLOBAL_AGGREGATION = 2'h1;
  localparam logic [1:0] ADDR_MCIDX = 2'h3;
  localparam logic [11:0] FLOOD_GROUP = 12'h000;

  typedef struct packed {
    logic entry_valid;
    logic locked;
    logic [1:0] age_flag;
    logic [1:0] addr_type;
    logic [11:0] addr;
    logic [47:0] mac;
    logic [12:0] fid;
    logic cpu_copy;
    logic [2:0] cpu_queue;
    logic src_drop;
    logic entry_skip_vlan;
    logic mirror;
    logic [1:0] age_interval;
  } lls_entry_type;

  typedef struct packed {
    logic [47:0] dmac;
    logic [47:0] smac;
    logic [12:0] egress_filter_id;
    logic [12:0] ingress_filter_id;
    logic [12:0] fid;
    logic [3:0] rx_port;
    logic [4:0] unit_id;
    logic global_aggregation_member;
    logic [4:0] global_aggregation_number;
    logic vlan_flood_allowed;
    logic vlan_secure_forward_enable;
  } lls_frame_type;

  typedef struct packed {
    logic flood;
    logic flood_blocked;
    logic [NPORT-1:0] dest_ports;
    logic mirror;
    logic dest_cpu_copy;
    logic [2:0] dest_cpu_queue;
    logic skip_vlan_mask;
    logic skip_src_mask;
    logic forward_denied;
    logic learn_copy;
    logic [2:0] learn_queue;
    logic src_known;
    logic learned;
  } lls_result_type;
endpackage : lls_pkg
